// *** sec_pkg.sv ***
// constants and types of the two-wire eeprom slave with security and cache
package sec_pkg;

  // ---------------------------------------------------------------
  // array and cache geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 13;
  localparam int MEM_BYTES   = 8192;
  localparam int CACHE_BYTES = 64;
  localparam int CIDX_W      = 6;
  localparam int PAGE_BYTES  = 8;
  localparam int PAGE_W      = 10;
  localparam int BLK_LSB     = 9;

  // ---------------------------------------------------------------
  // addressing byte, first address byte, configuration byte
  // ---------------------------------------------------------------
  localparam logic [3:0] TYPE_CODE    = 4'hA;
  localparam int         CTL_TYPE_LSB = 4;
  localparam int         CTL_SEL_LSB  = 1;
  localparam int         CTL_RW_BIT   = 0;
  localparam int         AHI_CFG_BIT  = 7;
  localparam int         AHI_BLK_LSB  = 1;
  localparam int         AHI_ADDR_W   = 5;
  localparam int         CFG_SHE_BIT  = 7;
  localparam int         CFG_RD_BIT   = 6;
  localparam int         CFG_CNT_LSB  = 0;

  // ---------------------------------------------------------------
  // reset values and readback upper nibble
  // ---------------------------------------------------------------
  localparam logic [3:0] PROT_START_RST = 4'hF;
  localparam logic [3:0] PROT_COUNT_RST = 4'h0;
  localparam logic [3:0] HE_BLOCK_RST   = 4'hF;
  localparam logic [3:0] RB_UPPER       = 4'hF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 20;
  localparam int T_PAGE_WR_US  = 5000;
  localparam int PAGE_WR_CYC   = T_PAGE_WR_US * CLK_MHZ;
  localparam int STOP_IDLE_CYC = 4;

  typedef enum logic [2:0] {
    st_idle, st_ctrl, st_ahi, st_alo, st_scfg, st_wdata, st_read
  } sec_state_t;

  typedef enum logic [1:0] {
    kind_none, kind_wr, kind_prot, kind_he
  } sec_kind_t;

endpackage

// *** sec_eeprom.sv ***
// two-wire eeprom slave: reads, security options, write cache
// Function
// - read command is a write command with direction bit set to one
// - address counter holds last accessed location plus one
// - current read: ack addressing byte, send one byte, stop on nack
// - random read: pointer latched from write address before restart
// - sequential read: each master ack sends the next byte
// - pointer advances by one after each byte operation; on writes only its low six bits count
// - config byte bit 7 clear sets the high-endurance block
// - high-endurance block locked after protection set; default top
// - protect 0 to 15 blocks from start; default start 15 count 0
// - protection settings programmable only once
// - protection write: first address byte bit 7, start in bits 1-4
// - don't-care byte, then config byte with count in bits 0-3
// - writes to protected locations silently dropped, others kept
// - readback: config bit 6 set, device returns two bytes
// - readback bytes: upper nibble ones, start then count
// - addressing byte not acknowledged during a write cycle
// - all commands ignored while a write cycle runs
// - 64-byte cache of eight pages loads until stop
// - each loaded page takes one full page write time
// - cache load index wraps to page 0 after 64 bytes
// - cache pages go to consecutive array pages
// - addressing byte: type code, select bits, direction; ack on match
// - first byte lands in page 0 at the low three address bits
module sec_eeprom
  import sec_pkg::*;
#(
  parameter int PAGE_WR_CYCLES = PAGE_WR_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // two-wire link
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b,
  input  wire logic [2:0] chip_select_inputs,
  // status
  output logic            write_busy,
  output logic            prot_locked,
  output logic [3:0]      prot_start,
  output logic [3:0]      prot_count,
  output logic [3:0]      he_block
);

  localparam int TMR_W = $clog2(PAGE_WR_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PAGE_WR_CYCLES - 1);

  if (PAGE_WR_CYCLES < PAGE_BYTES) begin
    $error("PAGE_WR_CYCLES must cover one page of byte writes");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]        mem       [MEM_BYTES];
  logic [7:0]        cache_mem [CACHE_BYTES];

  // ---------------------------------------------------------------
  // link domain state
  // ---------------------------------------------------------------
  logic              link_por_b;
  logic              link_frm_b;
  sec_state_t        st;
  logic [3:0]        cnt;
  logic [7:0]        sh;
  logic [7:0]        txd;
  logic              ack_go;
  logic              sda_pos;
  logic              start_n;
  logic              cfg;
  logic [3:0]        cfg_blk;
  logic [3:0]        pend_cnt;
  sec_kind_t         fr_kind;
  logic [AHI_ADDR_W-1:0] fr_hi;
  logic [PAGE_W-1:0] fr_page;
  logic [CIDX_W-1:0] ld;
  logic [CACHE_BYTES-1:0] cvalid;
  logic              rb_mode;
  logic [ADDR_W-1:0] ptr;
  logic              busy_l1;
  logic              busy_l2;
  logic [2:0]        cs_l1;
  logic [2:0]        cs_l2;
  logic [7:0]        rx_byte;
  logic              addr_match;
  logic              byte_done;
  logic              cache_we;
  logic              ptr_set;
  logic              ptr_rd;

  // ---------------------------------------------------------------
  // ref domain state
  // ---------------------------------------------------------------
  logic              scl_s1;
  logic              scl_s2;
  logic              sda_s1;
  logic              sda_s2;
  logic [2:0]        hi_cnt;
  logic              active;
  logic              stop_det;
  logic [2:0]        pg;
  logic [TMR_W-1:0]  tmr;
  logic [PAGE_W-1:0] wr_page;
  logic [CACHE_BYTES-1:0] cv;
  logic              page_loaded;
  logic [CIDX_W-1:0] ci;
  logic [ADDR_W-1:0] wa;
  logic              mem_we;

  function automatic logic prot_hit(input logic [3:0] blk,
                                    input logic [3:0] p_start,
                                    input logic [3:0] p_count);
    logic [4:0] top;
    top = {1'b0, p_start} + {1'b0, p_count};
    prot_hit = (p_count != 4'h0) && (blk >= p_start)
               && ({1'b0, blk} < top);
  endfunction

  // ---------------------------------------------------------------
  // link decode
  // ---------------------------------------------------------------
  assign rx_byte    = {sh[6:0], sda_in};
  assign addr_match = (rx_byte[7:CTL_TYPE_LSB] == TYPE_CODE)
                      && (rx_byte[CTL_TYPE_LSB-1:CTL_SEL_LSB] == cs_l2)
                      && !busy_l2;
  assign byte_done  = !start_n && (st != st_idle) && (st != st_read)
                      && (cnt == 4'd8) && ack_go;
  assign cache_we   = byte_done && (st == st_wdata);
  assign ptr_set    = byte_done && (st == st_alo) && !cfg;
  assign ptr_rd     = (byte_done && (st == st_ctrl) && sh[CTL_RW_BIT])
                      || (!start_n && (st == st_read) && (cnt == 4'd8)
                          && !sda_in && !rb_mode);
  assign sda_out    = 1'b0;

  // ---------------------------------------------------------------
  // link: level crossings into the serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge scl_clk or negedge link_frm_b) begin
    if (!link_frm_b) begin
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
      cs_l1   <= 3'h0;
      cs_l2   <= 3'h0;
    end else begin
      busy_l1 <= write_busy;
      busy_l2 <= busy_l1;
      cs_l1   <= chip_select_inputs;
      cs_l2   <= cs_l1;
    end
  end

  // ---------------------------------------------------------------
  // link: byte engine on the rising serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge scl_clk or negedge link_frm_b) begin
    if (!link_frm_b) begin
      st       <= st_idle;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      txd      <= 8'h00;
      ack_go   <= 1'b0;
      sda_pos  <= 1'b1;
      cfg      <= 1'b0;
      cfg_blk  <= 4'h0;
      pend_cnt <= 4'h0;
      fr_kind  <= kind_none;
      fr_hi    <= '0;
      fr_page  <= '0;
      ld       <= '0;
      cvalid   <= '0;
      rb_mode  <= 1'b0;
    end else begin
      sda_pos <= sda_in;
      if (start_n) begin
        st      <= st_ctrl;
        cnt     <= 4'd1;
        sh      <= {7'h00, sda_in};
        ack_go  <= 1'b0;
        fr_kind <= kind_none;
      end else if (st == st_read) begin
        if (cnt != 4'd8) begin
          cnt <= cnt + 4'd1;
        end else if (!sda_in) begin
          cnt <= 4'h0;
          if (rb_mode) begin
            txd <= {RB_UPPER, prot_count};
          end else begin
            txd <= mem[ptr];
          end
        end else begin
          st <= st_idle;
        end
      end else if (st != st_idle) begin
        if (cnt != 4'd8) begin
          sh  <= rx_byte;
          cnt <= cnt + 4'd1;
          if (cnt == 4'd7) begin
            ack_go <= (st != st_ctrl) || addr_match;
          end
        end else begin
          cnt <= 4'h0;
          if (!ack_go) begin
            st <= st_idle;
          end else begin
            unique case (st)
              st_ctrl: begin
                if (sh[CTL_RW_BIT]) begin
                  st      <= st_read;
                  rb_mode <= 1'b0;
                  txd     <= mem[ptr];
                end else begin
                  st <= st_ahi;
                end
              end
              st_ahi: begin
                cfg     <= sh[AHI_CFG_BIT];
                cfg_blk <= sh[AHI_BLK_LSB +: 4];
                fr_hi   <= sh[AHI_ADDR_W-1:0];
                st      <= st_alo;
              end
              st_alo: begin
                if (cfg) begin
                  st <= st_scfg;
                end else begin
                  fr_page <= {fr_hi, sh[7:3]};
                  ld      <= {3'h0, sh[2:0]};
                  cvalid  <= '0;
                  st      <= st_wdata;
                end
              end
              st_scfg: begin
                st <= st_idle;
                if (!sh[CFG_SHE_BIT]) begin
                  fr_kind <= kind_he;
                end else if (sh[CFG_RD_BIT]) begin
                  st      <= st_read;
                  rb_mode <= 1'b1;
                  txd     <= {RB_UPPER, prot_start};
                end else begin
                  pend_cnt <= sh[CFG_CNT_LSB +: 4];
                  fr_kind  <= kind_prot;
                end
              end
              st_wdata: begin
                cvalid[ld] <= 1'b1;
                ld         <= ld + 6'd1;
                fr_kind    <= kind_wr;
              end
              default: begin
                st <= st_idle;
              end
            endcase
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // link: cache loading
  // ---------------------------------------------------------------
  always_ff @(posedge scl_clk) begin
    if (cache_we) begin
      cache_mem[ld] <= sh;
    end
  end

  // ---------------------------------------------------------------
  // link: address pointer, kept across frames
  // ---------------------------------------------------------------
  always_ff @(posedge scl_clk or negedge link_por_b) begin
    if (!link_por_b) begin
      ptr <= '0;
    end else if (ptr_rd) begin
      ptr <= ptr + 13'h0001;
    end else if (ptr_set) begin
      ptr <= {fr_hi, sh};
    end else if (cache_we) begin
      ptr[5:0] <= ptr[5:0] + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // link: start detect and data drive on the falling serial clock
  // ---------------------------------------------------------------
  always_ff @(negedge scl_clk or negedge link_frm_b) begin
    if (!link_frm_b) begin
      start_n  <= 1'b0;
      sda_oe_b <= 1'b1;
    end else begin
      start_n <= sda_pos && !sda_in;
      if (sda_pos && !sda_in) begin
        sda_oe_b <= 1'b1;
      end else if (st == st_read) begin
        sda_oe_b <= (cnt == 4'd8) ? 1'b1 : txd[~cnt[2:0]];
      end else begin
        sda_oe_b <= !((st != st_idle) && (cnt == 4'd8) && ack_go);
      end
    end
  end

  // ---------------------------------------------------------------
  // ref: link resets and line synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    link_por_b <= rst_b;
    link_frm_b <= rst_b && !stop_det;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_clk;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // ---------------------------------------------------------------
  // ref: stop taken as both lines high after activity
  // ---------------------------------------------------------------
  assign stop_det = active && scl_s2 && sda_s2
                    && (hi_cnt == 3'(STOP_IDLE_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hi_cnt <= 3'h0;
      active <= 1'b0;
    end else if (!(scl_s2 && sda_s2)) begin
      hi_cnt <= 3'h0;
      active <= active || !scl_s2;
    end else if (stop_det) begin
      active <= 1'b0;
    end else if (hi_cnt != 3'(STOP_IDLE_CYC - 1)) begin
      hi_cnt <= hi_cnt + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // ref: one-time security settings, endurance block rewritable until lock
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prot_start  <= PROT_START_RST;
      prot_count  <= PROT_COUNT_RST;
      he_block    <= HE_BLOCK_RST;
      prot_locked <= 1'b0;
    end else if (stop_det && !prot_locked) begin
      if (fr_kind == kind_prot) begin
        prot_start  <= cfg_blk;
        prot_count  <= pend_cnt;
        prot_locked <= 1'b1;
      end else if (fr_kind == kind_he) begin
        he_block <= cfg_blk;
      end
    end
  end

  // ---------------------------------------------------------------
  // ref: page write engine
  // ---------------------------------------------------------------
  assign page_loaded = |cv[{pg, 3'h0} +: PAGE_BYTES];
  assign ci          = {pg, tmr[2:0]};
  assign wa          = {wr_page + PAGE_W'(pg), tmr[2:0]};
  assign mem_we      = write_busy && page_loaded
                       && (tmr < TMR_W'(PAGE_BYTES)) && cv[ci]
                       && !prot_hit(wa[ADDR_W-1:BLK_LSB],
                                    prot_start, prot_count);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      write_busy <= 1'b0;
      pg         <= 3'h0;
      tmr        <= '0;
      wr_page    <= '0;
      cv         <= '0;
    end else if (!write_busy) begin
      if (stop_det && (fr_kind == kind_wr)) begin
        write_busy <= 1'b1;
        pg         <= 3'h0;
        tmr        <= '0;
        wr_page    <= fr_page;
        cv         <= cvalid;
      end
    end else if (!page_loaded || (tmr == TMR_LAST)) begin
      tmr <= '0;
      pg  <= pg + 3'h1;
      if (pg == 3'h7) begin
        write_busy <= 1'b0;
      end
    end else begin
      tmr <= tmr + TMR_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[wa] <= cache_mem[ci];
    end
  end

endmodule

// *** sec_eeprom_chk.sv ***
// assertion checker for the two-wire eeprom slave
module sec_eeprom_chk
  import sec_pkg::*;
#(
  parameter int PAGE_WR_CYCLES = PAGE_WR_CYC
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // two-wire link
  input wire logic       scl_clk,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_b,
  input wire logic [2:0] chip_select_inputs,
  // status
  input wire logic       write_busy,
  input wire logic       prot_locked,
  input wire logic [3:0] prot_start,
  input wire logic [3:0] prot_count,
  input wire logic [3:0] he_block
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [31:0] busy_len;
  logic        idle;
  assign idle = scl_clk && sda_in;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !write_busy) begin
      busy_len <= 32'h0000_0000;
    end else begin
      busy_len <= busy_len + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_busy_run;
    write_busy [*2];
  endsequence
  sequence s_bus_quiet;
    idle [*8];
  endsequence
  property p_rst_val;
    $rose(rst_b) |-> prot_start == PROT_START_RST && !prot_locked &&
      prot_count == PROT_COUNT_RST && he_block == HE_BLOCK_RST && !write_busy;
  endproperty
  property p_default;
    !prot_locked |-> prot_start == PROT_START_RST &&
      prot_count == PROT_COUNT_RST;
  endproperty
  property p_lock_hold;
    prot_locked |=> prot_locked && $stable(prot_start) && $stable(prot_count);
  endproperty
  property p_cfg_change;
    $changed(prot_start) || $changed(prot_count) |-> $rose(prot_locked);
  endproperty
  property p_he_lock;
    prot_locked |=> $stable(he_block);
  endproperty
  property p_he_at_stop;
    $changed(he_block) |-> !$past(prot_locked) && $past(idle);
  endproperty
  property p_no_ack_busy;
    s_busy_run |-> sda_oe_b;
  endproperty
  property p_busy_after_stop;
    $rose(write_busy) |-> $past(idle) && $past(idle, 4);
  endproperty
  property p_busy_min;
    $fell(write_busy) |-> busy_len >= PAGE_WR_CYCLES;
  endproperty
  property p_busy_max;
    $fell(write_busy) |-> busy_len <= 8 * PAGE_WR_CYCLES + 8;
  endproperty
  property p_quiet_release;
    s_bus_quiet |=> sda_oe_b;
  endproperty
  property p_open_drain;
    !sda_oe_b |-> !sda_out;
  endproperty

  a_rst_val: assert property (p_rst_val)
    else $error("status not at reset values");
  a_default: assert property (p_default)
    else $error("protection moved while unlocked");
  a_lock_hold: assert property (p_lock_hold)
    else $error("protection changed after lock");
  a_cfg_change: assert property (p_cfg_change)
    else $error("protection changed without lock");
  a_he_lock: assert property (p_he_lock)
    else $error("endurance block changed after lock");
  a_he_at_stop: assert property (p_he_at_stop)
    else $error("endurance block changed outside stop");
  a_no_ack_busy: assert property (p_no_ack_busy)
    else $error("data line pulled during write cycle");
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("write cycle began without stop");
  a_busy_min: assert property (p_busy_min)
    else $error("write cycle too short");
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle too long");
  a_quiet_release: assert property (p_quiet_release)
    else $error("data line pulled on idle bus");
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
endmodule

bind sec_eeprom sec_eeprom_chk #(.PAGE_WR_CYCLES(PAGE_WR_CYCLES)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_b(sda_oe_b),
  .chip_select_inputs(chip_select_inputs), .write_busy(write_busy),
  .prot_locked(prot_locked), .prot_start(prot_start),
  .prot_count(prot_count), .he_block(he_block));

// *** sec_mst.sv ***
// two-wire bus master model driving the serial clock
module sec_mst (
  // two-wire link
  output logic      scl_clk,
  output logic      sda_oe_b,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands high and data released outside frames
  initial begin
    scl_clk = 1'b1;
    sda_oe_b = 1'b1;
  end
  task automatic bit_io(input logic o, output logic i);
    #20 sda_oe_b = o;
    #20 scl_clk = 1'b1;
    #20 i = sda_in;
    #20 scl_clk = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #20 scl_clk = 1'b0;
    #20 sda_oe_b = 1'b1;
    #20 scl_clk = 1'b1;
    #20 sda_oe_b = 1'b0;
    #20 scl_clk = 1'b0;
  endtask
  // stop, then bus idle long enough to be seen
  task automatic stop();
    #20 sda_oe_b = 1'b0;
    #20 scl_clk = 1'b1;
    #20 sda_oe_b = 1'b1;
    #400;
  endtask
  // byte out msb first, ack when the slot reads low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bit_io(b[k], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // byte in, ack pulls the slot low to continue
  task automatic rbyte(output logic [7:0] b, input logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bit_io(1'b1, b[k]);
    end
    bit_io(!ack, s);
  endtask
endmodule

// *** sec_eeprom_tb_top.sv ***
// self-checking bench of the two-wire eeprom slave
`define CHK(x, e) begin checked++; if ((x) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h vs %h", $time, (x), (e)); end end
module sec_eeprom_tb_top import sec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 64;
  localparam logic [12:0] WA [4] = '{13'h03F8, 13'h01F0, 13'h00A2, 13'h1FFC};
  localparam int WN [4] = '{16, 64, 66, 8};
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [2:0] cs = 3'h0;
  logic       scl_clk, m_oe_b, d_oe_b, sda_w, busy, lock, a;
  logic [3:0] ps, pc, he, hb;
  logic [3:0] t_start = 4'hF;
  logic [3:0] t_cnt = 4'h0;
  logic [7:0] d;
  logic [7:0] mem [0:8191];
  logic       kn [0:8191];
  logic [12:0] ad;
  int         n;
  int         failures = 0;
  int         checked = 0;
  assign sda_w = m_oe_b & d_oe_b;
  sec_eeprom #(.PAGE_WR_CYCLES(P)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_w),
    .sda_out(), .sda_oe_b(d_oe_b), .chip_select_inputs(cs),
    .write_busy(busy), .prot_locked(lock), .prot_start(ps),
    .prot_count(pc), .he_block(he));
  sec_mst i_mst (.scl_clk(scl_clk), .sda_oe_b(m_oe_b), .sda_in(sda_w));
  always #25 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic prot(input logic [12:0] x);
    return t_cnt != 4'h0 && x[12:9] >= t_start &&
      {1'b0, x[12:9]} < {1'b0, t_start} + {1'b0, t_cnt};
  endfunction
  function automatic logic [12:0] spot(input logic [12:0] x, input int k);
    return {x[12:3], 3'h0} + 13'((x[2:0] + k) % 64);
  endfunction
  task automatic put(input logic [7:0] b, input logic e);
    i_mst.wbyte(b, a);
    `CHK(a, e)
  endtask
  task automatic head(input logic [12:0] x, input logic rw);
    i_mst.start();
    put({TYPE_CODE, cs, rw}, 1'b1);
  endtask
  task automatic wr(input logic [12:0] x, input int m);
    int k;
    head(x, 1'b0);
    put({3'h0, x[12:8]}, 1'b1);
    put(x[7:0], 1'b1);
    for (k = 0; k < m; k++) begin
      d = 8'($urandom);
      put(d, 1'b1);
      if (!prot(spot(x, k))) begin
        mem[spot(x, k)] = d;
        kn[spot(x, k)] = 1'b1;
      end
    end
    i_mst.stop();
    k = 0;
    do begin
      i_mst.start();
      i_mst.wbyte({TYPE_CODE, cs, 1'b0}, a);
      if (!a) i_mst.stop();
      k++;
    end while (!a && k < 200);
    `CHK({a, k > 1}, 2'b11)
  endtask
  task automatic rd(input logic [12:0] x, input int m);
    head(x, 1'b0);
    put({3'h0, x[12:8]}, 1'b1);
    put(x[7:0], 1'b1);
    head(x, 1'b1);
    for (int k = 0; k < m; k++) begin
      i_mst.rbyte(d, k < m - 1);
      if (kn[13'(x + k)] === 1'b1) `CHK(d, mem[13'(x + k)])
    end
    i_mst.stop();
    head(x, 1'b1);
    i_mst.rbyte(d, 1'b0);
    i_mst.stop();
    if (kn[13'(x + m)] === 1'b1) `CHK(d, mem[13'(x + m)])
  endtask
  task automatic cfg(input logic [3:0] s, input logic [7:0] third);
    head(13'h0000, 1'b0);
    put({1'b1, 2'($urandom), s, 1'($urandom)}, 1'b1);
    put(8'($urandom), 1'b1);
    put(third, 1'b1);
  endtask
  task automatic cfg_end();
    i_mst.stop();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic rb();
    cfg(4'($urandom), {2'b11, 6'($urandom)});
    i_mst.rbyte(d, 1'b1);
    `CHK(d, {RB_UPPER, t_start})
    i_mst.rbyte(d, 1'b0);
    `CHK(d, {RB_UPPER, t_cnt})
    i_mst.stop();
  endtask
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #3_000_000;
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h5a4c));
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    cs <= 3'($urandom);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK({ps, pc, he, lock, busy}, {PROT_START_RST, PROT_COUNT_RST, HE_BLOCK_RST, 2'b00})
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      ad = i < 4 ? WA[i] : 13'($urandom);
      n = i < 4 ? WN[i] : 1 + $urandom % 20;
      wr(ad, n);
      rd(ad, n);
    end
    $display("test write read done");
    rb();
    hb = 4'($urandom);
    cfg(hb, 8'h00);
    cfg_end();
    `CHK(he, hb)
    cfg(4'h2, {2'b10, 2'($urandom), 4'h3});
    cfg_end();
    t_start = 4'h2;
    t_cnt = 4'h3;
    `CHK({lock, ps, pc}, {1'b1, 4'h2, 4'h3})
    cfg(4'h5, 8'h81);
    cfg_end();
    cfg(4'h7, 8'h00);
    cfg_end();
    `CHK({ps, pc, he}, {4'h2, 4'h3, hb})
    rb();
    wr(13'h03F8, 16);
    rd(13'h03F8, 16);
    $display("test security done");
    @(posedge ref_clk) cs <= 3'($urandom);
    #1;
    for (int j = 0; j < 8; j++) begin
      i_mst.start();
      put({j == 0 ? 4'hB : TYPE_CODE, cs ^ 3'(j), 1'b0}, 1'b0);
      i_mst.stop();
    end
    rd(13'h03F8, 4);
    $display("test select done");
    end_of_test();
  end
endmodule
